// ===== logic/fast_shutdown_and_cut_disable.v
`timescale 1ns/100ps
`default_nettype none
`include "fast_shutdown_consts.vh"

// What this block does
// - register 15h: upper nibble shutdown selects, lower nibble cut disables, reset zero
// - fast shutdown with multibit select low powers off selected channels only
// - cut disable set: overload fault alone never turns the channel off
// - current-limit faults still turn the channel off regardless of cut disable
// - overload fault flag still sets, timeout equal to the overload time
// - any change of a cut disable bit restarts that channel's overload timer
// - fast shutdown acts like channel reset but keeps cool-down timers running
// - shutdown clears event bits and disconnect, overload, inrush, limit fault bits
// - shutdown clears power good/enable, class/detect enables, autoclass, fault, foldback
// - shutdown reloads two-pair policing value with all ones
// - shutdown clears voltage, current, resistance and autoclass readings
// - shutdown clears requested, assigned and previous class and detection results
// - clean-up of affected state may take up to five milliseconds
// - only channels selected for shutdown are cleared, others stay unchanged
// - register 16h timing configuration, read/write, reset zero
// - timing fields msb to lsb: limit, inrush, overload, hold dropout
module fast_shutdown_and_cut_disable #(
  parameter                 CHANNELS  = 4,
  parameter                 TMR_W     = 24,
  parameter [TMR_W-1:0]     OVLD_CYC0 = `OVLD_CYC0_DEF,
  parameter [TMR_W-1:0]     OVLD_CYC1 = `OVLD_CYC1_DEF,
  parameter [TMR_W-1:0]     OVLD_CYC2 = `OVLD_CYC2_DEF,
  parameter [TMR_W-1:0]     OVLD_CYC3 = `OVLD_CYC3_DEF,
  parameter [TMR_W-1:0]     CLEAR_CYC = `CLEAR_CYC_DEF
) (
  // clock and reset
  input  wire                i_ref_clk,
  input  wire                i_rst_b,
  // command port
  input  wire                i_cmd_valid,
  input  wire                i_cmd_write,
  input  wire [7:0]          i_cmd_code,
  input  wire [7:0]          i_cmd_wdata,
  output reg  [7:0]          o_rd_data_ff,
  output reg                 o_rd_valid_ff,
  // shutdown control
  input  wire                i_fast_shutdown_input,
  input  wire                i_multibit_priority_select,
  // per-channel fault conditions
  input  wire [CHANNELS-1:0] i_power_cut_fault,
  input  wire [CHANNELS-1:0] i_current_limit_fault,
  input  wire [CHANNELS-1:0] i_fault_flag_clear,
  // per-channel results
  output reg  [CHANNELS-1:0] o_channel_off_ff,
  output reg  [CHANNELS-1:0] o_state_clear_ff,
  output reg  [CHANNELS-1:0] o_policing_reload_ff,
  output reg  [CHANNELS-1:0] o_clear_busy_ff,
  output reg  [CHANNELS-1:0] o_overload_fault_flag_ff,
  // register contents
  output reg  [7:0]          o_prio_cut_ff,
  output reg  [7:0]          o_timing_cfg_ff
);

  // ****************************************************************
  // functions
  // ****************************************************************
  function [TMR_W-1:0] ovld_limit;
    input [1:0] sel;
    begin
      case (sel)
        `OVLD_SEL_0: ovld_limit = OVLD_CYC0;
        `OVLD_SEL_1: ovld_limit = OVLD_CYC1;
        `OVLD_SEL_2: ovld_limit = OVLD_CYC2;
        default:     ovld_limit = OVLD_CYC3;
      endcase
    end
  endfunction

  // command code match, shared by write and read paths
  function hit_code;
    input [7:0] code;
    input [7:0] target;
    begin
      hit_code = (code == target);
    end
  endfunction

  // ****************************************************************
  // register access
  // ****************************************************************
  wire cmd_wr = i_cmd_valid & i_cmd_write;
  wire cmd_rd = i_cmd_valid & ~i_cmd_write;

  always @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_prio_cut_ff <= `PRIO_CUT_RST;
    end
    else if (cmd_wr && hit_code(i_cmd_code, `CMD_PRIO_CUT))
    begin
      o_prio_cut_ff <= i_cmd_wdata;
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_timing_cfg_ff <= `TIMING_CFG_RST;
    end
    else if (cmd_wr && hit_code(i_cmd_code, `CMD_TIMING_CFG))
    begin
      o_timing_cfg_ff <= i_cmd_wdata;
    end
  end

  // ****************************************************************
  // read port
  // ****************************************************************
  reg [7:0] nxt_rd_data;

  // unmapped codes read as zero, so a bad code never echoes stale data
  always @*
  begin
    nxt_rd_data = `READ_IDLE_VAL;
    if (cmd_rd && hit_code(i_cmd_code, `CMD_PRIO_CUT))
      nxt_rd_data = o_prio_cut_ff;
    else if (cmd_rd && hit_code(i_cmd_code, `CMD_TIMING_CFG))
      nxt_rd_data = o_timing_cfg_ff;
  end

  always @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_rd_data_ff <= `READ_IDLE_VAL;
    end
    else
    begin
      o_rd_data_ff <= nxt_rd_data;
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_rd_valid_ff <= 1'b0;
    end
    else
    begin
      o_rd_valid_ff <= cmd_rd;
    end
  end

  wire [CHANNELS-1:0] shutdown_sel = o_prio_cut_ff[`PRIO_MSB:`PRIO_LSB];
  wire [CHANNELS-1:0] cut_dis      = o_prio_cut_ff[`CUT_DIS_MSB:`CUT_DIS_LSB];
  // overload field shared by all channels
  wire [1:0]          ovld_sel     = o_timing_cfg_ff[`OVLD_TIME_MSB:`OVLD_TIME_LSB];
  wire [TMR_W-1:0]    ovld_max     = ovld_limit(ovld_sel);

  // ****************************************************************
  // fast shutdown synchroniser
  // ****************************************************************
  reg sd_meta_ff;
  reg sd_sync_ff;

  always @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      sd_meta_ff <= 1'b0;
      sd_sync_ff <= 1'b0;
    end
    else
    begin
      sd_meta_ff <= i_fast_shutdown_input;
      sd_sync_ff <= sd_meta_ff;
    end
  end

  // selects assumed clear when multibit set
  wire [CHANNELS-1:0] sd_hit = {CHANNELS{sd_sync_ff & ~i_multibit_priority_select}}
                               & shutdown_sel;

  reg  [CHANNELS-1:0] cut_dis_prev_ff;
  reg  [CHANNELS-1:0] sd_prev_ff;

  always @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cut_dis_prev_ff <= {CHANNELS{1'b0}};
      sd_prev_ff      <= {CHANNELS{1'b0}};
    end
    else
    begin
      cut_dis_prev_ff <= cut_dis;
      sd_prev_ff      <= sd_hit;
    end
  end

  // ****************************************************************
  // per-channel overload timer and turn-off
  // ****************************************************************
  wire [CHANNELS-1:0] sd_new;
  wire [CHANNELS-1:0] ovld_out;
  wire [CHANNELS-1:0] clr_done;

  genvar ch;
  generate
    for (ch = 0; ch < CHANNELS; ch = ch + 1)
    begin : g_chan
      reg  [TMR_W-1:0] ovld_tmr_ff;
      reg  [TMR_W-1:0] nxt_ovld_tmr;
      reg  [TMR_W-1:0] clr_tmr_ff;
      reg  [TMR_W-1:0] nxt_clr_tmr;

      assign sd_new[ch]   = sd_hit[ch] & ~sd_prev_ff[ch];
      assign ovld_out[ch] = i_power_cut_fault[ch] & (ovld_tmr_ff >= ovld_max);
      assign clr_done[ch] = (clr_tmr_ff == {TMR_W{1'b0}});

      always @*
      begin
        nxt_ovld_tmr = ovld_tmr_ff;
        if (cut_dis[ch] != cut_dis_prev_ff[ch])
          nxt_ovld_tmr = {TMR_W{1'b0}};
        else if (!i_power_cut_fault[ch] || sd_hit[ch])
          nxt_ovld_tmr = {TMR_W{1'b0}};
        else if (ovld_tmr_ff < ovld_max)
          nxt_ovld_tmr = ovld_tmr_ff + {{(TMR_W-1){1'b0}}, 1'b1};
      end

      always @*
      begin
        nxt_clr_tmr = clr_tmr_ff;
        if (sd_new[ch])
          nxt_clr_tmr = CLEAR_CYC;
        else if (!clr_done[ch])
          nxt_clr_tmr = clr_tmr_ff - {{(TMR_W-1){1'b0}}, 1'b1};
      end

      always @(posedge i_ref_clk or negedge i_rst_b)
      begin
        if (!i_rst_b)
        begin
          ovld_tmr_ff <= {TMR_W{1'b0}};
          clr_tmr_ff  <= {TMR_W{1'b0}};
        end
        else
        begin
          ovld_tmr_ff <= nxt_ovld_tmr;
          clr_tmr_ff  <= nxt_clr_tmr;
        end
      end
    end
  endgenerate

  // ****************************************************************
  // next values of the channel outputs
  // ****************************************************************
  reg [CHANNELS-1:0] nxt_channel_off;
  reg [CHANNELS-1:0] nxt_state_clear;
  reg [CHANNELS-1:0] nxt_policing_reload;
  reg [CHANNELS-1:0] nxt_clear_busy;
  reg [CHANNELS-1:0] nxt_overload_flag;

  always @*
  begin
    // cut turn-off only when not disabled
    nxt_channel_off = sd_hit | i_current_limit_fault | (ovld_out & ~cut_dis);
    // clear pulse also drives external fault bits
    // power and enable bits cleared externally
    nxt_state_clear = sd_new;
    nxt_policing_reload = sd_new;
    // cool-down timers live elsewhere and get no clear
    nxt_clear_busy = sd_new | (o_clear_busy_ff & ~clr_done);
    // flag sets even when cut disabled; set beats clear
    nxt_overload_flag = ovld_out
                        | (o_overload_fault_flag_ff & ~(sd_new | i_fault_flag_clear));
  end

  // ****************************************************************
  // channel output registers
  // ****************************************************************
  always @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_channel_off_ff <= {CHANNELS{1'b0}};
    end
    else
    begin
      o_channel_off_ff <= nxt_channel_off;
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_state_clear_ff <= {CHANNELS{1'b0}};
    end
    else
    begin
      o_state_clear_ff <= nxt_state_clear;
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_policing_reload_ff <= {CHANNELS{1'b0}};
    end
    else
    begin
      o_policing_reload_ff <= nxt_policing_reload;
    end
  end

  // busy outlasts the pulse; the host must not trust read-back before it drops
  always @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_clear_busy_ff <= {CHANNELS{1'b0}};
    end
    else
    begin
      o_clear_busy_ff <= nxt_clear_busy;
    end
  end

  always @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_overload_fault_flag_ff <= {CHANNELS{1'b0}};
    end
    else
    begin
      o_overload_fault_flag_ff <= nxt_overload_flag;
    end
  end

endmodule
`default_nettype wire

// ===== logic/fast_shutdown_consts.vh
`ifndef FAST_SHUTDOWN_CONSTS_VH
`define FAST_SHUTDOWN_CONSTS_VH

// command codes
`define CMD_PRIO_CUT        8'h15
`define CMD_TIMING_CFG      8'h16
`define CMD_MBIT_PRIO_REG   8'h17

// reset values
`define PRIO_CUT_RST        8'h00
`define TIMING_CFG_RST      8'h00
`define READ_IDLE_VAL       8'h00

// field positions, shutdown_priority_cut_disable
`define PRIO_MSB            7
`define PRIO_LSB            4
`define CUT_DIS_MSB         3
`define CUT_DIS_LSB         0

// field positions, channel_timing_config
`define LIM_TIME_MSB        7
`define LIM_TIME_LSB        6
`define INRUSH_TIME_MSB     5
`define INRUSH_TIME_LSB     4
`define OVLD_TIME_MSB       3
`define OVLD_TIME_LSB       2
`define HOLD_DROP_MSB       1
`define HOLD_DROP_LSB       0

// overload time select codes
`define OVLD_SEL_0          2'h0
`define OVLD_SEL_1          2'h1
`define OVLD_SEL_2          2'h2

// clean-up window after a fast shutdown, 5 ms of 200 MHz cycles
`define CLEAR_CYC_DEF       24'h0F4240

// overload windows in cycles; plain defaults, set per board
`define OVLD_CYC0_DEF       24'h0B71B0
`define OVLD_CYC1_DEF       24'h16E360
`define OVLD_CYC2_DEF       24'h2DC6C0
`define OVLD_CYC3_DEF       24'h5B8D80

`endif

// ===== tb/fast_shutdown_checker.sv
`timescale 1ns/100ps
`default_nettype none
// ***
// checker
// ***
module fast_shutdown_checker #(parameter CHANNELS = 4) (
  // watched ports
  input wire logic                i_ref_clk,
  input wire logic                i_rst_b,
  input wire logic                i_fast_shutdown_input,
  input wire logic                i_multibit_priority_select,
  input wire logic [CHANNELS-1:0] i_power_cut_fault,
  input wire logic [CHANNELS-1:0] i_current_limit_fault,
  input wire logic [CHANNELS-1:0] i_fault_flag_clear,
  input wire logic [CHANNELS-1:0] o_channel_off_ff,
  input wire logic [CHANNELS-1:0] o_state_clear_ff,
  input wire logic [CHANNELS-1:0] o_policing_reload_ff,
  input wire logic [CHANNELS-1:0] o_clear_busy_ff,
  input wire logic [CHANNELS-1:0] o_overload_fault_flag_ff,
  input wire logic [7:0]          o_prio_cut_ff
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  wire [3:0] sel = o_prio_cut_ff[7:4];
  a_sel_off: assert property ((i_fast_shutdown_input && !i_multibit_priority_select
    && $stable(sel))[*3]
    |=> (o_channel_off_ff & sel) == sel) else $error("selected channel on");
  a_cut_hold: assert property (o_prio_cut_ff[0] && !sel[0] && !i_current_limit_fault[0]
    && !o_channel_off_ff[0] |=> !o_channel_off_ff[0]) else $error("cut disable ignored");
  a_limit_off: assert property (1 |=> (o_channel_off_ff & $past(i_current_limit_fault))
    == $past(i_current_limit_fault)) else $error("limit left on");
  a_flag_set: assert property ((i_power_cut_fault[0] && !i_fault_flag_clear[0])[*8]
    |-> ##[0:3] o_overload_fault_flag_ff[0]) else $error("no overload flag");
  a_clear_pulse: assert property (|o_state_clear_ff |=>
    (o_state_clear_ff & $past(o_state_clear_ff)) == 0) else $error("clear too long");
  a_reload_pair: assert property (o_policing_reload_ff == o_state_clear_ff)
    else $error("reload apart");
  a_busy_cover: assert property (|o_state_clear_ff |->
    (o_clear_busy_ff & o_state_clear_ff) == o_state_clear_ff) else $error("busy missing");
  a_clear_sel: assert property (|o_state_clear_ff |-> (o_state_clear_ff & ~sel) == 0)
    else $error("unselected cleared");
  c_clear: cover property (|o_state_clear_ff);
  c_flag: cover property ($rose(o_overload_fault_flag_ff[0]));
  c_limit: cover property (|i_current_limit_fault);
endmodule
bind fast_shutdown_and_cut_disable fast_shutdown_checker #(.CHANNELS(CHANNELS)) chk (.*);
`default_nettype wire

// ===== tb/host_cmd_model.sv
`timescale 1ns/100ps
`default_nettype none
// ***
// host
// ***
module host_cmd_model (
  // clock and answer
  input  wire logic       i_ref_clk,
  input  wire logic [7:0] i_rd_data,
  // command
  output var  logic       o_cmd_valid = 1'b0,
  output var  logic       o_cmd_write = 1'b0,
  output var  logic [7:0] o_cmd_code = 8'h00,
  output var  logic [7:0] o_cmd_wdata = 8'h00
);
  // one command, released only after its taking edge
  task automatic xfer(input logic w, input logic [7:0] c, input logic [7:0] d,
                      output logic [7:0] r);
    @(negedge i_ref_clk);
    o_cmd_valid = 1'b1;
    o_cmd_write = w;
    o_cmd_code  = c;
    o_cmd_wdata = d;
    @(negedge i_ref_clk);
    o_cmd_valid = 1'b0;
    r = i_rd_data;
  endtask
endmodule
`default_nettype wire

// ===== tb/fast_shutdown_and_cut_disable_test.sv
`timescale 1ns/100ps
`default_nettype none
// ***
// bench
// ***
module fast_shutdown_and_cut_disable_test;
  logic       clk, rst_b, sd, mbs, cv, cw;
  logic [7:0] cc, cd, rdd, q;
  logic [3:0] pcf, clf, ffc, off, clr, rld, busy, flag;
  int         errors, check_count;
  fast_shutdown_and_cut_disable #(.OVLD_CYC0(24'h000008), .CLEAR_CYC(24'h000014)) dut (
    .i_ref_clk(clk), .i_rst_b(rst_b), .i_cmd_valid(cv), .i_cmd_write(cw), .i_cmd_code(cc),
    .i_cmd_wdata(cd), .o_rd_data_ff(rdd), .o_rd_valid_ff(), .i_fast_shutdown_input(sd),
    .i_multibit_priority_select(mbs), .i_power_cut_fault(pcf), .i_current_limit_fault(clf),
    .i_fault_flag_clear(ffc), .o_channel_off_ff(off), .o_state_clear_ff(clr),
    .o_policing_reload_ff(rld), .o_clear_busy_ff(busy), .o_overload_fault_flag_ff(flag),
    .o_prio_cut_ff(), .o_timing_cfg_ff());
  host_cmd_model h (.i_ref_clk(clk), .i_rd_data(rdd), .o_cmd_valid(cv), .o_cmd_write(cw),
    .o_cmd_code(cc), .o_cmd_wdata(cd));
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    errors += int'(got !== exp);
    if (got !== exp) $display("[ERR] %0t got %h exp %h", $time, got, exp);
  endtask
  task automatic t_regs;
    h.xfer(1'b0, 8'h15, 8'h00, q);
    chk(q, 8'h00);
    h.xfer(1'b0, 8'h16, 8'h00, q);
    chk(q, 8'h00);
    h.xfer(1'b0, 8'h17, 8'h00, q);
    chk(q, 8'h00);
    h.xfer(1'b1, 8'h16, 8'h1B, q);
    h.xfer(1'b0, 8'h16, 8'h00, q);
    chk(q, 8'h1B);
    h.xfer(1'b1, 8'h16, 8'h00, q);
    h.xfer(1'b1, 8'h15, 8'hA5, q);
    h.xfer(1'b0, 8'h15, 8'h00, q);
    chk(q, 8'hA5);
  endtask
  task automatic t_cut;
    clf = 4'h1;
    @(negedge clk);
    clf = 4'h0;
    chk({4'h0, off}, 8'h01);
    pcf = 4'h2;
    repeat (2) @(negedge clk);
    h.xfer(1'b1, 8'h15, 8'hA7, q);
    h.xfer(1'b1, 8'h15, 8'hA5, q);
    repeat (6) @(negedge clk);
    chk({4'h0, flag}, 8'h00);
    pcf = 4'h3;
    repeat (10) @(negedge clk);
    pcf = 4'h0;
    chk({off, flag}, 8'h23);
  endtask
  task automatic t_sd;
    sd = 1'b1;
    repeat (3) @(negedge clk);
    chk({off, clr}, 8'hAA);
    chk({rld, flag}, 8'hA1);
    @(negedge clk);
    chk({clr, busy}, 8'h0A);
    repeat (20) @(negedge clk);
    sd = 1'b0;
    ffc = 4'h1;
    chk({4'h0, busy}, 8'h00);
    repeat (3) @(negedge clk);
    chk({off, flag}, 8'h00);
  endtask
  task automatic final_report;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  initial
  begin
    // multibit mode kept off, selects stay usable
    {rst_b, sd, mbs} = 3'h0;
    {pcf, clf, ffc} = 12'h000;
    repeat (5) @(negedge clk);
    rst_b = 1'b1;
    t_regs();
    t_cut();
    t_sd();
    final_report();
  end
endmodule
`default_nettype wire
